// ===== rtl/ddpc_pkg.sv
package ddpc_pkg;
    // Special-function addresses of the unit
    localparam logic [7:0] DDPC_ADDR_CTRL = 8'ha7;
    // Byte registers of the active pointer; addresses chosen for this unit
    localparam logic [7:0] DDPC_ADDR_LOW = 8'h82;
    localparam logic [7:0] DDPC_ADDR_HIGH = 8'h83;
    localparam logic [7:0] DDPC_ADDR_PAGE = 8'h84;
    // Control field positions
    localparam int DDPC_BIT_SEL = 0;
    localparam int DDPC_BIT_SWAP = 6;
    localparam int DDPC_MAIN_LO = 2;
    localparam int DDPC_SHAD_LO = 4;
    // Writable control bits: 6..2 and 0
    localparam logic [7:0] DDPC_CTRL_MASK = 8'h7d;
    localparam logic [7:0] DDPC_CTRL_RST = 8'h00;
    localparam logic [23:0] DDPC_PTR_RST = 24'h000000;
    // Pointer step modes
    localparam logic [1:0] DDPC_MODE_KEEP = 2'h0;
    localparam logic [1:0] DDPC_MODE_INC = 2'h1;
    localparam logic [1:0] DDPC_MODE_DEC = 2'h2;
    localparam logic [1:0] DDPC_MODE_TGL = 2'h3;
endpackage

// ===== rtl/ddpc_ptr_store.sv
`timescale 1ns/10ps
// Holds main and shadow pointers; one word written per cycle
module ddpc_ptr_store (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic wr_sel_i,
    input wire logic [23:0] wr_data_i,
    output logic [23:0] main_q_o,
    output logic [23:0] shad_q_o
);
    // Both words stay visible so the stepping logic reads without a port
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_q_o <= ddpc_pkg::DDPC_PTR_RST;
            shad_q_o <= ddpc_pkg::DDPC_PTR_RST;
        end else if (wr_en_i && !wr_sel_i) begin
            main_q_o <= wr_data_i;
        end else if (wr_en_i && wr_sel_i) begin
            shad_q_o <= wr_data_i;
        end
    end
endmodule

// ===== rtl/ddpc_top.sv
`timescale 1ns/10ps
// Dual data pointer unit with its control register
module ddpc_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sfr_wr_i,            // Special-function write strobe
    input wire logic [7:0] sfr_addr_i,    // Special-function address
    input wire logic [7:0] sfr_wdata_i,   // Write data
    output logic [7:0] sfr_rdata_o,       // Read data of addressed register
    output logic sfr_hit_o,               // Address belongs to this unit
    input wire logic ptr_move_i,          // Pointer-addressed MOVC/MOVX done
    input wire logic ptr_load_i,          // Full 24-bit load of active pointer
    input wire logic [23:0] ptr_load_data_i,
    output logic [23:0] data_pointer_o,   // Active pointer for addressing
    output logic pointer_select_o
);
    logic [7:0] ctrl_q; // Control register, bits 7 and 1 always zero
    logic [7:0] ctrl_d; // Next control value
    logic [23:0] main_q; // Main pointer from the store
    logic [23:0] shad_q; // Shadow pointer from the store
    logic [7:0] rdata_q; // Registered read data
    logic [23:0] active_q; // Registered copy of the active pointer

    // Step a pointer by its mode, wrapping at 24 bits
    function automatic logic [23:0] ddpc_step(input logic [23:0] p, input logic [1:0] m);
        logic [23:0] r;
        r = p;
        unique case (m)
            ddpc_pkg::DDPC_MODE_KEEP: r = p;
            ddpc_pkg::DDPC_MODE_INC: r = p + 24'h000001;
            ddpc_pkg::DDPC_MODE_DEC: r = p - 24'h000001;
            ddpc_pkg::DDPC_MODE_TGL: r = p ^ 24'h000001;
        endcase
        return r;
    endfunction

    // Field views of the control register
    wire sel = ctrl_q[ddpc_pkg::DDPC_BIT_SEL];
    wire swap_en = ctrl_q[ddpc_pkg::DDPC_BIT_SWAP];
    wire [1:0] main_mode = ctrl_q[ddpc_pkg::DDPC_MAIN_LO +: 2];
    wire [1:0] shad_mode = ctrl_q[ddpc_pkg::DDPC_SHAD_LO +: 2];
    wire [23:0] active = sel ? shad_q : main_q;

    // Address decode
    wire hit_ctrl = sfr_addr_i == ddpc_pkg::DDPC_ADDR_CTRL;
    wire hit_low = sfr_addr_i == ddpc_pkg::DDPC_ADDR_LOW;
    wire hit_high = sfr_addr_i == ddpc_pkg::DDPC_ADDR_HIGH;
    wire hit_page = sfr_addr_i == ddpc_pkg::DDPC_ADDR_PAGE;
    wire byte_wr = sfr_wr_i && (hit_low || hit_high || hit_page);

    // Byte write merges into the selected pointer only
    wire [23:0] byte_merge = hit_low ? {active[23:8], sfr_wdata_i} :
                             hit_high ? {active[23:16], sfr_wdata_i, active[7:0]} :
                             {sfr_wdata_i, active[15:0]};

    // Move steps only the pointer in use; load and byte writes override
    wire [1:0] use_mode = sel ? shad_mode : main_mode;
    wire [23:0] stepped = ddpc_step(active, use_mode);
    wire ptr_wr = ptr_move_i || ptr_load_i || byte_wr;
    wire [23:0] ptr_wdata = ptr_load_i ? ptr_load_data_i :
                            byte_wr ? byte_merge : stepped;

    ddpc_ptr_store u_store (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(ptr_wr),
        .wr_sel_i(sel),
        .wr_data_i(ptr_wdata),
        .main_q_o(main_q),
        .shad_q_o(shad_q)
    );

    // Control next value: writes mask bits 7 and 1, a move may swap select.
    // A write of the control register in the same cycle as a move wins; the
    // core never issues both at once.
    wire [7:0] ctrl_wr_val = sfr_wdata_i & ddpc_pkg::DDPC_CTRL_MASK;
    wire [7:0] ctrl_swap = ctrl_q ^ 8'h01;
    always_comb begin
        ctrl_d = ctrl_q;
        if (sfr_wr_i && hit_ctrl) begin
            ctrl_d = ctrl_wr_val;
        end else if (ptr_move_i && swap_en) begin
            ctrl_d = ctrl_swap;
        end
    end

    // Control register, clears to zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= ddpc_pkg::DDPC_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Next values of both pointers; they mirror the store's write so the
    // active view can be registered without a cycle of lag
    wire [23:0] main_d = (ptr_wr && !sel) ? ptr_wdata : main_q;
    wire [23:0] shad_d = (ptr_wr && sel) ? ptr_wdata : shad_q;
    wire [23:0] active_d = ctrl_d[ddpc_pkg::DDPC_BIT_SEL] ? shad_d : main_d;

    // Active pointer in its own flops: costs 24 flops, but the address
    // output no longer carries the select mux behind it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_q <= ddpc_pkg::DDPC_PTR_RST;
        end else begin
            active_q <= active_d;
        end
    end

    // Registered read data of the addressed byte
    wire [7:0] rd_mux = hit_ctrl ? ctrl_q :
                        hit_low ? active[7:0] :
                        hit_high ? active[15:8] :
                        hit_page ? active[23:16] : 8'h00;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign sfr_hit_o = hit_ctrl || hit_low || hit_high || hit_page;
    assign data_pointer_o = active_q;
    assign pointer_select_o = sel;

    // Checks
    sequence move_s;
        ptr_move_i && !ptr_load_i && !sfr_wr_i;
    endsequence
    // Full load with nothing else that could move the select
    sequence load_s;
        ptr_load_i && !ptr_move_i && !sfr_wr_i;
    endsequence
    // Byte write of a pointer register that nothing overrides
    sequence byte_wr_s;
        byte_wr && !ptr_load_i && !ptr_move_i;
    endsequence
    // Write of the control register
    sequence ctrl_wr_s;
        sfr_wr_i && hit_ctrl;
    endsequence

    swap_on_move_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and swap_en |=> pointer_select_o != $past(pointer_select_o))
        else $error("select did not swap after move");
    no_swap_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !swap_en |=> pointer_select_o == $past(pointer_select_o))
        else $error("select swapped while auto-swap off");
    main_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !sel && main_mode == 2'h1 |=> main_q == $past(main_q) + 24'h000001)
        else $error("main pointer not incremented");
    shad_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and sel && shad_mode == 2'h2 |=> shad_q == $past(shad_q) - 24'h000001)
        else $error("shadow pointer not decremented");
    bit_one_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_q[1] == 1'b0 && ctrl_q[7] == 1'b0)
        else $error("unimplemented control bit set");
    active_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        data_pointer_o == (pointer_select_o ? shad_q : main_q))
        else $error("active pointer not mapped");
    idle_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ptr_move_i && !ptr_load_i && !sfr_wr_i |=> $stable(main_q) && $stable(shad_q) && $stable(ctrl_q))
        else $error("pointer changed without trigger");
    other_kept_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !sel |=> shad_q == $past(shad_q))
        else $error("unused pointer changed by move");
    ctrl_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hit_ctrl |=> sfr_rdata_o == $past(ctrl_q))
        else $error("control read wrong");

    // Remaining step modes of each pointer
    main_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !sel && main_mode == ddpc_pkg::DDPC_MODE_DEC |=> main_q == $past(main_q) - 24'h000001)
        else $error("main pointer not decremented");
    main_tgl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !sel && main_mode == ddpc_pkg::DDPC_MODE_TGL |=> main_q == ($past(main_q) ^ 24'h000001))
        else $error("main pointer low bit not toggled");
    main_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and !sel && main_mode == ddpc_pkg::DDPC_MODE_KEEP |=> $stable(main_q))
        else $error("main pointer changed in keep mode");
    shad_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and sel && shad_mode == ddpc_pkg::DDPC_MODE_INC |=> shad_q == $past(shad_q) + 24'h000001)
        else $error("shadow pointer not incremented");
    shad_tgl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and sel && shad_mode == ddpc_pkg::DDPC_MODE_TGL |=> shad_q == ($past(shad_q) ^ 24'h000001))
        else $error("shadow pointer low bit not toggled");
    shad_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and sel && shad_mode == ddpc_pkg::DDPC_MODE_KEEP |=> $stable(shad_q))
        else $error("shadow pointer changed in keep mode");

    // The pointer not in use keeps its value
    main_kept_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        move_s and sel |=> $stable(main_q))
        else $error("main pointer changed by shadow move");

    // Loads and byte writes reach the active pointer only
    load_active_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        load_s |=> data_pointer_o == $past(ptr_load_data_i))
        else $error("load did not reach active pointer");
    load_no_swap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        load_s |=> $stable(pointer_select_o))
        else $error("select changed by load");
    byte_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_wr_s and hit_low |=> data_pointer_o[7:0] == $past(sfr_wdata_i))
        else $error("low byte write lost");
    byte_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_wr_s and hit_high |=> data_pointer_o[15:8] == $past(sfr_wdata_i))
        else $error("high byte write lost");
    byte_page_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_wr_s and hit_page |=> data_pointer_o[23:16] == $past(sfr_wdata_i))
        else $error("page byte write lost");
    byte_other_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_wr_s and !sel |=> $stable(shad_q))
        else $error("byte write reached shadow pointer");

    // Control writes keep bits 7 and 1 clear; unmapped reads give zero
    ctrl_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_wr_s |=> ctrl_q == ($past(sfr_wdata_i) & ddpc_pkg::DDPC_CTRL_MASK))
        else $error("control write not masked");
    rd_unmapped_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !sfr_hit_o |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule

// ===== testbench/ddpc_core_model.sv
`timescale 1ns/10ps
// Core side of the unit: one write, move, load or read per call
module ddpc_core_model (
    input wire logic ref_clk_i,
    output logic sfr_wr_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic ptr_move_o,
    output logic ptr_load_o,
    output logic [23:0] ptr_load_data_o
);
    // Idle core: no strobes, data lines carry a filler pattern
    initial begin
        sfr_wr_o = 1'b0;
        ptr_move_o = 1'b0;
        ptr_load_o = 1'b0;
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h5a;
        ptr_load_data_o = 24'ha5a5a5;
    end
    // Kind 0 write, 1 move, 2 load, 3 address only; strobe stands one cycle
    task automatic op(input logic [1:0] kind, input logic [7:0] addr, input logic [23:0] data);
        @(negedge ref_clk_i);
        sfr_addr_o = addr;
        sfr_wdata_o = data[7:0];
        ptr_load_data_o = data;
        sfr_wr_o = (kind == 2'h0);
        ptr_move_o = (kind == 2'h1);
        ptr_load_o = (kind == 2'h2);
        @(negedge ref_clk_i);
        sfr_wr_o = 1'b0;
        ptr_move_o = 1'b0;
        ptr_load_o = 1'b0;
        // Released data is inverted so a stale capture cannot pass
        sfr_wdata_o = ~data[7:0];
        ptr_load_data_o = ~data;
    endtask
endmodule

// ===== testbench/dual_data_pointer_control_tb.sv
`timescale 1ns/10ps
// Self-checking bench: reset checks and mode table first, then masking, swap, byte-write and mid-run reset cases
module dual_data_pointer_control_tb;
    logic ref_clk_i;
    logic rst_n_i;
    logic sfr_wr, ptr_move, ptr_load, sfr_hit, pointer_select;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [23:0] load_data, data_pointer;
    int n_errors = 0;
    int checked = 0;
    // Rows: control byte, loaded pointer, pointer expected after one move
    logic [55:0] rows [8] = '{56'h00_123456_123456, 56'h04_ffffff_000000, 56'h08_000000_ffffff,
        56'h0c_000011_000010, 56'h11_00ffff_010000, 56'h21_000100_0000ff, 56'h31_000000_000001,
        56'h01_abcdef_abcdef};
    ddpc_core_model i_core (.ref_clk_i(ref_clk_i), .sfr_wr_o(sfr_wr), .sfr_addr_o(sfr_addr),
        .sfr_wdata_o(sfr_wdata), .ptr_move_o(ptr_move), .ptr_load_o(ptr_load), .ptr_load_data_o(load_data));
    ddpc_top i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_wr_i(sfr_wr), .sfr_addr_i(sfr_addr),
        .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit), .ptr_move_i(ptr_move),
        .ptr_load_i(ptr_load), .ptr_load_data_i(load_data), .data_pointer_o(data_pointer),
        .pointer_select_o(pointer_select));
    // Free-running 200 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // One comparison; four-state equality so unknowns fail
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Single exit point of the run
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reads take a cycle: address, edge, then sample
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        i_core.op(2'h3, addr, 24'h000000);
        chk("read data", {16'h0000, exp}, {16'h0000, sfr_rdata});
    endtask
    // Cuts a hang short
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
    initial begin
        rst_n_i = 1'b0;
        repeat (16) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        chk("reset pointer", 24'h000000, data_pointer);
        rd(ddpc_pkg::DDPC_ADDR_CTRL, 8'h00);
        chk("control hit", 24'h000001, {23'h000000, sfr_hit});
        // Every step mode of both pointers, no swap
        foreach (rows[i]) begin
            i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, {16'h0000, rows[i][55:48]});
            i_core.op(2'h2, 8'h00, rows[i][47:24]);
            i_core.op(2'h1, 8'h00, 24'h000000);
            chk("stepped pointer", rows[i][23:0], data_pointer);
            chk("select", {23'h000000, rows[i][48]}, {23'h000000, pointer_select});
        end
        // Bits 7 and 1 are dropped on write
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h0000ff);
        rd(ddpc_pkg::DDPC_ADDR_CTRL, 8'h7d);
        // A read is no move: select stays even with auto-swap on
        chk("select kept", 24'h000001, {23'h000000, pointer_select});
        // Write of 7e: bit 1 is dropped, the rest reads back as 7c
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h00007e);
        rd(ddpc_pkg::DDPC_ADDR_CTRL, 8'h7c);
        // Copy-loop walk: main at 0, shadow at d000, both incrementing with swap
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h000054);
        i_core.op(2'h2, 8'h00, 24'h000000);
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h000055);
        i_core.op(2'h2, 8'h00, 24'h00d000);
        i_core.op(2'h1, 8'h00, 24'h000000);
        chk("main after swap", 24'h000000, data_pointer);
        chk("select after swap", 24'h000000, {23'h000000, pointer_select});
        i_core.op(2'h1, 8'h00, 24'h000000);
        chk("shadow after swap", 24'h00d001, data_pointer);
        rd(ddpc_pkg::DDPC_ADDR_LOW, 8'h01);
        rd(ddpc_pkg::DDPC_ADDR_HIGH, 8'hd0);
        rd(ddpc_pkg::DDPC_ADDR_PAGE, 8'h00);
        // Back to main: its increment from the second move shows
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h000054);
        chk("main pointer", 24'h000001, data_pointer);
        // Byte writes land in the selected pointer only
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_PAGE, 24'h000012);
        chk("page hit", 24'h000001, {23'h000000, sfr_hit});
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_HIGH, 24'h000034);
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_LOW, 24'h000056);
        chk("main bytes", 24'h123456, data_pointer);
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h000055);
        chk("shadow untouched", 24'h00d001, data_pointer);
        rd(8'h90, 8'h00);
        chk("unmapped hit", 24'h000000, {23'h000000, sfr_hit});
        // Reset in mid-run clears both pointers and the control register
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk("pointer in reset", 24'h000000, data_pointer);
        rst_n_i = 1'b1;
        chk("select after reset", 24'h000000, {23'h000000, pointer_select});
        rd(ddpc_pkg::DDPC_ADDR_CTRL, 8'h00);
        // Modes are cleared too, so a move leaves main where it is
        i_core.op(2'h1, 8'h00, 24'h000000);
        chk("move after reset", 24'h000000, data_pointer);
        i_core.op(2'h0, ddpc_pkg::DDPC_ADDR_CTRL, 24'h000001);
        chk("shadow after reset", 24'h000000, data_pointer);
        wrap_up();
    end
endmodule
